// [isw_sweep_seq.sv]
// impedance sweep sequencer top: registers, commands, sweep control
// assumes a byte register port on clk, dft results from the datapath
// How it works
// - A 24-bit step word is held over three bytes, high byte first.
// - Step word survives power-up and soft reset unchanged.
// - Point count is 9 bits, upper bits ignored, up to 511.
// - Point count survives power-up and soft reset.
// - Sweep range follows start word, step word and point count.
// - Start, step or repeat waits the settling cycles before converting.
// - Settling count 9 bits with x1, x2, x4 multiplier, max 2044.
// - Settling count and multiplier survive power-up and soft reset.
// - Each point takes 1024 samples then stores real and imaginary.
// - One conversion lasts about 1 ms at 16.777 MHz, scaling with clock.
// - Status bit 1 sets when a point's results are ready.
// - Bit 1 clears on reset, start, step, repeat or soft reset.
// - Status bit 2 sets when the last sweep point finishes.
// - Bit 2 clears on reset, start, soft reset; not on step or repeat.
// - Status bits 0 and 3 to 7 carry nothing and read zero.
// - Real and imaginary are 16-bit two's complement, high byte first.
// - Result registers survive power-up and soft reset.
// - Top control nibble: 0010 start, 0011 step, 0100 repeat.
// - Step command advances frequency, then waits settling, then converts.
// - Repeat command measures the same frequency again.
// - Soft reset aborts; initialize is needed before a new sweep.
`timescale 1ns/1ns
`default_nettype none
module isw_sweep_seq
  import isw_pkg::*;
#(
  parameter int CONV_CYCLES_P = CONV_CYCLES
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic [7:0] bus_addr,
  input wire logic [7:0] bus_wdata,
  input wire logic bus_wr,
  input wire logic bus_rd,
  output logic [7:0] bus_rdata,
  input wire logic exc_clk,
  input wire logic [23:0] start_word,
  input wire logic [15:0] dft_real,
  input wire logic [15:0] dft_imag,
  output logic [26:0] freq_word,
  output logic adc_sample,
  output logic point_valid,
  output logic sweep_done
);

  // ==========================================================
  // command decode
  logic wr_hi;
  logic soft_rst;
  logic cmd_init;
  logic cmd_start;
  logic cmd_incr;
  logic cmd_rep;
  logic go_settle;
  logic settle_done;
  logic done_evt;
  logic [15:0] conv_cnt_q;
  logic [8:0] idx_q;
  isw_state_t state_q;

  assign wr_hi = bus_wr && bus_addr == ADDR_CTRL_HI;
  assign soft_rst = bus_wr && bus_addr == ADDR_CTRL_LO
                    && bus_wdata[CTRL_RST_BIT];
  assign cmd_init = wr_hi && bus_wdata[7:4] == CMD_INIT;
  assign cmd_start = wr_hi && bus_wdata[7:4] == CMD_START;
  assign cmd_incr = wr_hi && bus_wdata[7:4] == CMD_INCR;
  assign cmd_rep = wr_hi && bus_wdata[7:4] == CMD_REPEAT;
  // start acts only after initialize; step and repeat only once a finished point exists
  assign go_settle = !soft_rst
    && ((state_q == ST_INIT && cmd_start)
        || (state_q == ST_HOLD && (cmd_incr || cmd_rep)));
  // an aborted conversion never reports a result
  assign done_evt = state_q == ST_CONV && conv_cnt_q == 16'h0000
                    && !soft_rst;

  // ==========================================================
  // sweep setup registers: step, count and settle have no reset on purpose, values persist
  logic [23:0] step_q;
  logic [8:0] count_q;
  logic [10:0] settle_q;
  logic [15:0] ctrl_q;

  always_ff @(posedge clk) begin
    if (bus_wr) begin
      unique case (bus_addr)
        ADDR_STEP_HI: step_q[23:16] <= bus_wdata;
        ADDR_STEP_MID: step_q[15:8] <= bus_wdata;
        ADDR_STEP_LO: step_q[7:0] <= bus_wdata;
        ADDR_COUNT_HI: count_q[8] <= bus_wdata[0];
        ADDR_COUNT_LO: count_q[7:0] <= bus_wdata;
        ADDR_SETTLE_HI: settle_q[10:8] <= bus_wdata[2:0];
        ADDR_SETTLE_LO: settle_q[7:0] <= bus_wdata;
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      ctrl_q <= CTRL_RESET;
    end else if (bus_wr && bus_addr == ADDR_CTRL_HI) begin
      ctrl_q[15:8] <= bus_wdata;
    end else if (bus_wr && bus_addr == ADDR_CTRL_LO) begin
      // reset bit is self-clearing
      ctrl_q[7:0] <= bus_wdata & ~(8'h01 << CTRL_RST_BIT);
    end
  end

  // ==========================================================
  // sequencing state machine
  always_ff @(posedge clk) begin
    if (srst) begin
      state_q <= ST_IDLE;
    end else if (soft_rst) begin
      state_q <= ST_IDLE;
    end else begin
      unique case (state_q)
        ST_IDLE: if (cmd_init) state_q <= ST_INIT;
        ST_INIT: if (go_settle) state_q <= ST_SETTLE;
        ST_SETTLE: if (settle_done) state_q <= ST_CONV;
        ST_CONV: if (done_evt) state_q <= ST_HOLD;
        ST_HOLD: begin
          if (go_settle) begin
            state_q <= ST_SETTLE;
          end else if (cmd_init) begin
            state_q <= ST_INIT;
          end
        end
      endcase
    end
  end

  isw_settle_timer u_settle (
    .clk(clk),
    .srst(srst),
    .exc_clk(exc_clk),
    .start(go_settle),
    .cycles(settle_q[8:0]),
    .mult(settle_q[10:9]),
    .done(settle_done)
  );

  // ==========================================================
  // frequency word and point index
  always_ff @(posedge clk) begin
    if (srst) begin
      freq_word <= 27'h0000000;
      idx_q <= 9'h000;
    end else if (cmd_init && !soft_rst
                 && (state_q == ST_IDLE || state_q == ST_HOLD)) begin
      freq_word <= {3'h0, start_word};
      idx_q <= 9'h000;
    end else if (go_settle && cmd_incr) begin
      freq_word <= freq_word + {3'h0, step_q};
      idx_q <= idx_q + 9'h001;
    end
  end

  // ==========================================================
  // conversion timing and result capture
  always_ff @(posedge clk) begin
    if (srst) begin
      conv_cnt_q <= 16'h0000;
      adc_sample <= 1'b0;
    end else begin
      adc_sample <= 1'b0;
      if (settle_done && state_q == ST_SETTLE && !soft_rst) begin
        conv_cnt_q <= 16'(CONV_CYCLES_P - 1);
      end else if (state_q == ST_CONV && conv_cnt_q != 16'h0000) begin
        conv_cnt_q <= conv_cnt_q - 16'h0001;
      end
      if (state_q == ST_CONV && conv_cnt_q[SAMPLE_DIV_W-1:0] == '0) begin
        adc_sample <= 1'b1;
      end
    end
  end

  logic [15:0] real_q;
  logic [15:0] imag_q;

  // results keep their last value through any reset
  always_ff @(posedge clk) begin
    if (done_evt) begin
      real_q <= dft_real;
      imag_q <= dft_imag;
    end
  end

  // ==========================================================
  // status flags: a finishing point wins over a same-cycle command clear; reset and soft reset win
  always_ff @(posedge clk) begin
    if (srst) begin
      point_valid <= 1'b0;
    end else if (done_evt) begin
      point_valid <= 1'b1;
    end else if (soft_rst || cmd_start || cmd_incr || cmd_rep) begin
      point_valid <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      sweep_done <= 1'b0;
    end else if (done_evt && idx_q == count_q) begin
      sweep_done <= 1'b1;
    end else if (soft_rst || cmd_start) begin
      sweep_done <= 1'b0;
    end
  end

  // ==========================================================
  // read path; unmapped addresses read zero
  always_ff @(posedge clk) begin
    if (srst) begin
      bus_rdata <= 8'h00;
    end else if (bus_rd) begin
      unique case (bus_addr)
        ADDR_CTRL_HI: bus_rdata <= ctrl_q[15:8];
        ADDR_CTRL_LO: bus_rdata <= ctrl_q[7:0];
        ADDR_STEP_HI: bus_rdata <= step_q[23:16];
        ADDR_STEP_MID: bus_rdata <= step_q[15:8];
        ADDR_STEP_LO: bus_rdata <= step_q[7:0];
        ADDR_COUNT_HI: bus_rdata <= {7'h00, count_q[8]};
        ADDR_COUNT_LO: bus_rdata <= count_q[7:0];
        ADDR_SETTLE_HI: bus_rdata <= {5'h00, settle_q[10:8]};
        ADDR_SETTLE_LO: bus_rdata <= settle_q[7:0];
        ADDR_STATUS: bus_rdata <= {5'h00, sweep_done, point_valid,
                                   1'b0};
        ADDR_REAL_HI: bus_rdata <= real_q[15:8];
        ADDR_REAL_LO: bus_rdata <= real_q[7:0];
        ADDR_IMAG_HI: bus_rdata <= imag_q[15:8];
        ADDR_IMAG_LO: bus_rdata <= imag_q[7:0];
        default: bus_rdata <= 8'h00;
      endcase
    end
  end

  // ==========================================================
  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  step_keep_a: assert property (
    soft_rst |=> $stable(step_q))
    else $error("step word changed by soft reset");

  count_keep_a: assert property (
    soft_rst |=> $stable(count_q))
    else $error("point count changed by soft reset");

  settle_keep_a: assert property (
    soft_rst |=> $stable(settle_q))
    else $error("settle count changed by soft reset");

  result_keep_a: assert property (
    soft_rst |=> $stable(real_q) && $stable(imag_q))
    else $error("results changed by soft reset");

  conv_after_wait_a: assert property (
    $rose(state_q == ST_CONV) |-> $past(settle_done))
    else $error("conversion began before settling");

  valid_clear_a: assert property (
    (cmd_start || cmd_incr || cmd_rep || soft_rst) && !done_evt
      |=> !point_valid)
    else $error("valid flag not cleared by command");

  valid_set_a: assert property (
    $rose(point_valid) |-> $past(state_q) == ST_CONV
      && $past(conv_cnt_q) == 16'h0000 && state_q == ST_HOLD)
    else $error("valid set without finished conversion");

  sweep_hold_a: assert property (
    (cmd_incr || cmd_rep) && !soft_rst && !done_evt |=> $stable(sweep_done))
    else $error("sweep flag touched by step or repeat");

  sweep_last_a: assert property (
    $rose(sweep_done) |-> $past(idx_q) == $past(count_q) && point_valid)
    else $error("sweep flag set before last point");

  freq_step_a: assert property (
    go_settle && cmd_incr |=> freq_word == $past(freq_word)
      + {3'h0, $past(step_q)})
    else $error("frequency did not advance by one step");

  repeat_same_a: assert property (
    go_settle && cmd_rep |=> $stable(freq_word) && $stable(idx_q))
    else $error("repeat changed frequency");

  init_needed_a: assert property (
    state_q == ST_IDLE && !cmd_init |=> state_q == ST_IDLE)
    else $error("sweep left idle without initialize");

  status_rsv_a: assert property (
    bus_rd && bus_addr == ADDR_STATUS |=> bus_rdata[0] == 1'b0
      && bus_rdata[7:3] == 5'h00)
    else $error("reserved status bits not zero");

endmodule : isw_sweep_seq
`default_nettype wire

// [isw_pkg.sv]
// impedance sweep sequencer: shared constants, types and helpers
// assumes a byte-wide register port and one 10 MHz system clock
package isw_pkg;

  // ==========================================================
  // register map (byte addresses)
  localparam logic [7:0] ADDR_CTRL_HI = 8'h80;
  localparam logic [7:0] ADDR_CTRL_LO = 8'h81;
  localparam logic [7:0] ADDR_STEP_HI = 8'h85;
  localparam logic [7:0] ADDR_STEP_MID = 8'h86;
  localparam logic [7:0] ADDR_STEP_LO = 8'h87;
  localparam logic [7:0] ADDR_COUNT_HI = 8'h88;
  localparam logic [7:0] ADDR_COUNT_LO = 8'h89;
  localparam logic [7:0] ADDR_SETTLE_HI = 8'h8a;
  localparam logic [7:0] ADDR_SETTLE_LO = 8'h8b;
  localparam logic [7:0] ADDR_STATUS = 8'h8f;
  localparam logic [7:0] ADDR_REAL_HI = 8'h94;
  localparam logic [7:0] ADDR_REAL_LO = 8'h95;
  localparam logic [7:0] ADDR_IMAG_HI = 8'h96;
  localparam logic [7:0] ADDR_IMAG_LO = 8'h97;

  // ==========================================================
  // fields, commands and reset values
  localparam int CTRL_RST_BIT = 4;
  localparam int STAT_VALID_BIT = 1;
  localparam int STAT_DONE_BIT = 2;
  localparam logic [15:0] CTRL_RESET = 16'ha000;
  localparam logic [3:0] CMD_INIT = 4'h1;
  localparam logic [3:0] CMD_START = 4'h2;
  localparam logic [3:0] CMD_INCR = 4'h3;
  localparam logic [3:0] CMD_REPEAT = 4'h4;
  localparam logic [1:0] MULT_X2 = 2'h1;
  localparam logic [1:0] MULT_X4 = 2'h3;

  // ==========================================================
  // conversion timing: 1024 samples, one per 16 system clocks
  localparam int SAMPLE_COUNT = 1024;
  localparam int SAMPLE_DIV = 16;
  localparam int SAMPLE_DIV_W = 4;
  localparam int CONV_CYCLES = SAMPLE_COUNT * SAMPLE_DIV;

  typedef enum logic [4:0] {
    ST_IDLE = 5'b00001,
    ST_INIT = 5'b00010,
    ST_SETTLE = 5'b00100,
    ST_CONV = 5'b01000,
    ST_HOLD = 5'b10000
  } isw_state_t;

  // settling cycles times multiplier; the reserved code acts as x1
  function automatic logic [10:0] settle_total(input logic [8:0] n,
                                               input logic [1:0] m);
    logic [10:0] r;
    r = {2'h0, n};
    if (m == MULT_X2) r = {1'h0, n, 1'h0};
    if (m == MULT_X4) r = {n, 2'h0};
    return r;
  endfunction : settle_total

endpackage : isw_pkg

// [isw_settle_timer.sv]
// settling wait: counts excitation cycles after a sweep command
// assumes exc_clk is the excitation square wave, asynchronous to clk
`timescale 1ns/1ns
`default_nettype none
module isw_settle_timer
  import isw_pkg::*;
(
  input wire logic clk,
  input wire logic srst,
  input wire logic exc_clk,
  input wire logic start,
  input wire logic [8:0] cycles,
  input wire logic [1:0] mult,
  output logic done
);

  // ==========================================================
  // excitation edge detection
  logic exc_meta_q;
  logic exc_sync_q;
  logic exc_prev_q;
  logic exc_rise;

  always_ff @(posedge clk) begin
    exc_meta_q <= exc_clk;
    exc_sync_q <= exc_meta_q;
    exc_prev_q <= exc_sync_q;
  end

  assign exc_rise = exc_sync_q & ~exc_prev_q;

  // ==========================================================
  // cycle counter
  logic active_q;
  logic [10:0] cnt_q;
  logic [10:0] target_q;

  always_ff @(posedge clk) begin
    if (srst) begin
      active_q <= 1'b0;
      cnt_q <= 11'h000;
      target_q <= 11'h000;
      done <= 1'b0;
    end else begin
      done <= 1'b0;
      if (start) begin
        active_q <= 1'b1;
        cnt_q <= 11'h000;
        target_q <= settle_total(cycles, mult);
      end else if (active_q) begin
        if (cnt_q == target_q) begin
          done <= 1'b1;
          active_q <= 1'b0;
        end else if (exc_rise) begin
          cnt_q <= cnt_q + 11'h001;
        end
      end
    end
  end

  done_after_wait_a: assert property (@(posedge clk) disable iff (srst)
    done |-> $past(active_q) && $past(cnt_q) == $past(target_q))
    else $error("settle done before programmed cycles");

endmodule : isw_settle_timer
`default_nettype wire

// [isw_front_model.sv]
// analog front end stand-in: excitation wave and dft result source
// assumes results follow the frequency word the sequencer drives
`timescale 1ns/1ns
`default_nettype none
module isw_front_model (
  input wire logic [26:0] freq_word,
  output var logic exc_clk,
  output logic [15:0] dft_real,
  output logic [15:0] dft_imag
);
  // ==========================================================
  // excitation: 800 ns period, phase kept off the clk edges
  initial begin
    exc_clk = 1'b0;
    #137;
    forever #400 exc_clk = ~exc_clk;
  end

  // ==========================================================
  // results tied to frequency so a stale capture shows up
  assign dft_real = freq_word[15:0];
  assign dft_imag = ~freq_word[15:0];
endmodule : isw_front_model
`default_nettype wire

// [tb_isw_sweep_seq.sv]
// self-checking bench for the sweep sequencer register port
// assumes the front model drives excitation and results
`timescale 1ns/1ns
`default_nettype none
module tb_isw_sweep_seq
  import isw_pkg::*;
;
  localparam int CONV = 64;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic [7:0] bus_addr = 8'h00;
  logic [7:0] bus_wdata = 8'h00;
  logic bus_wr = 1'b0;
  logic bus_rd = 1'b0;
  logic [23:0] start_word = 24'h000100;
  logic [7:0] bus_rdata;
  logic exc_clk;
  logic [15:0] dft_real;
  logic [15:0] dft_imag;
  logic [26:0] freq_word;
  logic adc_sample;
  logic point_valid;
  logic sweep_done;
  int num_errors = 0;
  int check_count = 0;
  int n;
  int f;

  isw_sweep_seq #(.CONV_CYCLES_P(CONV)) i_isw_sweep_seq (
    .clk(clk), .srst(srst), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
    .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata),
    .exc_clk(exc_clk), .start_word(start_word), .dft_real(dft_real),
    .dft_imag(dft_imag), .freq_word(freq_word), .adc_sample(adc_sample),
    .point_valid(point_valid), .sweep_done(sweep_done));

  isw_front_model i_isw_front_model (
    .freq_word(freq_word), .exc_clk(exc_clk), .dft_real(dft_real),
    .dft_imag(dft_imag));

  always #50 clk = ~clk;

  // ==========================================================
  // access tasks
  task automatic give_verdict();
    if (num_errors == 0 && check_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : give_verdict

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD t=%0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    #1 bus_wr = 1'b1;
    bus_addr = a;
    bus_wdata = d;
    @(posedge clk);
    #1 bus_wr = 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk);
    #1 bus_rd = 1'b1;
    bus_addr = a;
    @(posedge clk);
    #1 bus_rd = 1'b0;
    chk({24'h0, bus_rdata}, {24'h0, e});
  endtask : rd

  task automatic cmd(input logic [3:0] c);
    wr(ADDR_CTRL_HI, {c, 4'h0});
  endtask : cmd

  // bounded wait for point_valid, counting cycles and sample strobes
  task automatic wait_pt(output int cyc);
    int k;
    k = 0;
    cyc = 0;
    while (point_valid !== 1'b1) begin
      @(posedge clk);
      #1 cyc++;
      if (adc_sample === 1'b1) k++;
      if (cyc > 4000) begin
        num_errors++;
        $display("BAD t=%0t no point result", $time);
        give_verdict();
      end
    end
    chk(k, CONV / SAMPLE_DIV);
  endtask : wait_pt

  // results of point idx: real is the low word, imag its inverse
  task automatic res(input int idx);
    logic [15:0] v;
    v = 16'h0100 + 16'(idx * 16);
    rd(ADDR_REAL_HI, v[15:8]);
    rd(ADDR_REAL_LO, v[7:0]);
    rd(ADDR_IMAG_HI, ~v[15:8]);
    rd(ADDR_IMAG_LO, ~v[7:0]);
  endtask : res

  // ==========================================================
  // main sequence
  initial begin
    repeat (8) @(posedge clk);
    #1 srst = 1'b0;
    rd(ADDR_STATUS, 8'h00);
    wr(ADDR_STEP_HI, 8'h00);
    wr(ADDR_STEP_MID, 8'h00);
    wr(ADDR_STEP_LO, 8'h10);
    wr(ADDR_COUNT_HI, 8'hfe);
    wr(ADDR_COUNT_LO, 8'h02);
    wr(ADDR_SETTLE_HI, 8'hf8);
    wr(ADDR_SETTLE_LO, 8'h02);
    rd(ADDR_STEP_HI, 8'h00);
    rd(ADDR_STEP_LO, 8'h10);
    rd(ADDR_COUNT_HI, 8'h00);
    rd(ADDR_SETTLE_HI, 8'h00);
    rd(8'h90, 8'h00);
    cmd(CMD_INIT);
    cmd(CMD_START);
    wait_pt(n);
    rd(ADDR_STATUS, 8'h02);
    chk(32'(freq_word), 32'h100);
    res(0);
    cmd(CMD_INCR);
    rd(ADDR_STATUS, 8'h00);
    wait_pt(n);
    chk(32'(freq_word), 32'h110);
    res(1);
    cmd(CMD_REPEAT);
    wait_pt(n);
    chk(32'(freq_word), 32'h110);
    res(1);
    cmd(CMD_INCR);
    wait_pt(n);
    rd(ADDR_STATUS, 8'h06);
    res(2);
    cmd(CMD_REPEAT);
    rd(ADDR_STATUS, 8'h04);
    wait_pt(n);
    rd(ADDR_STATUS, 8'h06);
    wr(ADDR_CTRL_LO, 8'h10);
    rd(ADDR_STATUS, 8'h00);
    rd(ADDR_STEP_MID, 8'h00);
    rd(ADDR_STEP_LO, 8'h10);
    rd(ADDR_COUNT_LO, 8'h02);
    rd(ADDR_SETTLE_LO, 8'h02);
    res(2);
    cmd(CMD_START);
    repeat (300) @(posedge clk);
    #1 chk(32'(point_valid), 32'h0);
    cmd(CMD_INIT);
    cmd(CMD_START);
    wait_pt(n);
    // settle 3 cycles under each multiplier code, 8 clk per cycle
    for (int i = 0; i < 4; i++) begin
      f = (i == 1) ? 2 : ((i == 3) ? 4 : 1);
      wr(ADDR_SETTLE_HI, {5'h1f, 2'(i), 1'b0});
      wr(ADDR_SETTLE_LO, 8'h03);
      rd(ADDR_SETTLE_HI, {5'h00, 2'(i), 1'b0});
      cmd(CMD_REPEAT);
      wait_pt(n);
      chk(32'(n >= 24 * f + CONV - 8 && n <= 24 * f + CONV + 16), 1);
    end
    // run the second sweep out, then restart it from hold
    cmd(CMD_INCR);
    wait_pt(n);
    cmd(CMD_INCR);
    wait_pt(n);
    rd(ADDR_STATUS, 8'h06);
    cmd(CMD_INIT);
    chk(32'(freq_word), 32'h100);
    cmd(CMD_START);
    rd(ADDR_STATUS, 8'h00);
    wait_pt(n);
    rd(ADDR_STATUS, 8'h02);
    res(0);
    // power-up reset mid-run: setup and results must survive
    @(posedge clk);
    #1 srst = 1'b1;
    repeat (2) @(posedge clk);
    #1 srst = 1'b0;
    rd(ADDR_STATUS, 8'h00);
    rd(ADDR_STEP_LO, 8'h10);
    rd(ADDR_COUNT_LO, 8'h02);
    rd(ADDR_SETTLE_HI, 8'h06);
    res(0);
    give_verdict();
  end
endmodule : tb_isw_sweep_seq
`default_nettype wire
